//--- ai4_adc_model.sv
// behavioural converter answering the sequencer's channel requests
module ai4_adc_model
	import ai4_pkg::*;
(
	// clock
	input wire logic clk_sys,
	// request side
	input wire logic adcReq,
	input wire logic [1:0] adcChan,
	// answer side
	output logic adcValid,
	output logic [15:0] adcData,
	// bench controls
	input wire logic [NCH-1:0][15:0] rawIn,
	input wire logic [7:0] delay
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] cnt = 8'h00;
	logic busy = 1'b0;
	logic [15:0] held = 16'h0000;
	logic validOut = 1'b0;
	logic [15:0] dataOut = 16'h5A5A;
	assign adcValid = validOut;
	assign adcData = dataOut;

	// one answer per request after the chosen delay, data churns otherwise
	always @(posedge clk_sys)
	begin
		validOut <= 1'b0;
		if (adcReq)
		begin
			busy <= 1'b1;
			cnt <= delay;
			held <= rawIn[adcChan];
		end
		else if (busy && cnt != 8'h00)
			cnt <= cnt - 8'h01;
		else if (busy)
		begin
			busy <= 1'b0;
			validOut <= 1'b1;
			dataOut <= held;
		end
		else
			dataOut <= ~dataOut;
	end
endmodule

//--- ai4_pkg.sv
// constants, types and structures of the analog input processing block
package ai4_pkg;
	// channel and filter shape
	localparam int NCH = 4;
	localparam int MAXORD = 4;
	localparam int CNT_W = 16;
	// clock rate and derived timing
	localparam int CLK_MHZ = 250;
	localparam logic [7:0] CYC_PER_US = 8'hFA;
	localparam int SYNC_WIN_NS = 5000;
	localparam int SYNC_WIN_CYC = SYNC_WIN_NS * CLK_MHZ / 1000;
	localparam int LED_TICK_MS = 50;
	localparam int LED_TICK_CYC = LED_TICK_MS * CLK_MHZ * 1000;
	// indicator frame of 24 ticks, 200 ms flash slots
	localparam logic [4:0] LED_FRAME_END = 5'h17;
	localparam logic [4:0] LED_FLASH1_END = 5'h04;
	localparam logic [4:0] LED_FLASH2_BEG = 5'h08;
	localparam logic [4:0] LED_FLASH2_END = 5'h0C;
	// filter coefficient arithmetic, Q32 of 2*pi*1e-6, unity in Q15 and Q16
	localparam logic [15:0] W_SCALE = 16'h696A;
	localparam logic [16:0] A_ONE = 17'h08000;
	localparam logic [63:0] W_ONE = 64'h0000_0000_0001_0000;
	// per-stage cutoff factors 1/sqrt(2^(1/n)-1), Q8, n = 1..4
	localparam logic [9:0] FC_F1 = 10'h100;
	localparam logic [9:0] FC_F2 = 10'h18E;
	localparam logic [9:0] FC_F3 = 10'h1F6;
	localparam logic [9:0] FC_F4 = 10'h24D;
	// reset values, rail codes and counter step
	localparam logic [15:0] MIN_INIT = 16'h7FFF;
	localparam logic [15:0] MAX_INIT = 16'h8000;
	localparam logic [15:0] RAW_TOP = 16'h7FFF;
	localparam logic [15:0] RAW_VBOT = 16'h8001;
	localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

	// sequencer states
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_CREQ = 3'b001,
		S_CWAIT = 3'b010,
		S_PREP = 3'b011,
		S_FILT = 3'b100,
		S_SCALE = 3'b101,
		S_LIMIT = 3'b110
	} ai4_state_t;

	// module operating state from the module controller
	typedef enum logic [1:0] {
		DEV_RESET = 2'b00,
		DEV_BOOT = 2'b01,
		DEV_CONFIGURING_STATE = 2'b10,
		DEV_RUN = 2'b11
	} ai4_dev_t;

	// per-channel configuration
	typedef struct packed {
		logic enable;
		logic isCurrent;
		logic filtEn;
		logic scaleEn;
		logic staticErr;
		logic limitEn;
		logic recEn;
		logic [2:0] order;
		logic [15:0] cutoffHz;
		logic signed [31:0] userGain;
		logic signed [31:0] userOff;
		logic signed [31:0] calGain;
		logic signed [31:0] calOff;
		logic signed [31:0] minLim;
		logic signed [31:0] maxLim;
	} ai4_chcfg_t;

	// per-channel event counters
	typedef struct packed {
		logic [CNT_W-1:0] outRange;
		logic [CNT_W-1:0] under;
		logic [CNT_W-1:0] over;
		logic [CNT_W-1:0] latch;
	} ai4_chcnt_t;
endpackage

//--- ai4_proc.sv
// four-channel analog input conversion and processing sequencer
module ai4_proc
	import ai4_pkg::*;
#(
	parameter int TICK_CYC = LED_TICK_CYC,
	parameter int FIFO_DEPTH = 8192
)(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// module state
	input ai4_dev_t devState,
	input wire logic modError,
	// configuration
	input ai4_chcfg_t [NCH-1:0] chCfg,
	input wire logic [15:0] sampleTimeUs,
	// min/max period control
	input wire logic [NCH-1:0] minMaxCtl,
	input wire logic [NCH-1:0] trigRise,
	input wire logic [NCH-1:0] trigFall,
	// recording readout
	input wire logic traceTrig,
	input wire logic traceReady,
	output logic traceValid,
	output logic [15:0] traceData,
	// timing and front-end pins
	input wire logic busCycPin,
	input wire logic convTrigPin,
	input wire logic [NCH-1:0] openLinePin,
	// converter
	output logic adcReq,
	output logic [1:0] adcChan,
	input wire logic adcValid,
	input wire logic [15:0] adcData,
	// results
	output logic [NCH-1:0][15:0] chValue,
	output logic [NCH-1:0][15:0] minValue,
	output logic [NCH-1:0][15:0] maxValue,
	output logic [NCH-1:0] minMaxReadback,
	// status and counters
	output logic [NCH-1:0] chUnder,
	output logic [NCH-1:0] chOver,
	output logic [NCH-1:0] chOutRange,
	output logic syncErr,
	output logic cycleViol,
	output logic [CNT_W-1:0] sampleCycleCnt,
	output logic [CNT_W-1:0] syncErrCnt,
	output logic [CNT_W-1:0] sampleViolCnt,
	output ai4_chcnt_t [NCH-1:0] chCnt,
	// lamps
	output logic ledRun,
	output logic ledErr,
	output logic [NCH-1:0] ledCh
);
	localparam int AW = $clog2(FIFO_DEPTH);

	// event counter: steps whenever the error state changes
	function automatic logic [CNT_W-1:0] evtCnt(input logic [CNT_W-1:0] c,
		input logic was, input logic now);
		return (was != now) ? CNT_W'(c + CNT_ONE) : c;
	endfunction

	// filter coefficient a in Q15 from cutoff, order and sampling time
	function automatic logic [15:0] coefA(input logic [15:0] fc,
		input logic [2:0] ord, input logic [15:0] ts);
		logic [9:0] f;
		logic [63:0] fs;
		logic [63:0] w;
		logic [63:0] q;
		begin
			case (ord)
				3'd2: f = FC_F2;
				3'd3: f = FC_F3;
				3'd4: f = FC_F4;
				default: f = FC_F1;
			endcase
			fs = (64'(fc) * 64'(f)) >> 8;
			w = (fs * 64'(ts) * 64'(W_SCALE)) >> 16;
			q = (w << 15) / (W_ONE + w);
			return q[15:0];
		end
	endfunction

	// 16-bit saturation of a 32-bit value
	function automatic logic [15:0] sat16(input logic signed [31:0] v);
		if (v > 32'sd32767)
			return RAW_TOP;
		else if (v < -32'sd32768)
			return MAX_INIT;
		else
			return v[15:0];
	endfunction

	// pin synchronisers
	logic busMeta_reg, busSync_reg, busPrev_reg;
	logic convMeta_reg, convSync_reg, convPrev_reg;
	logic [NCH-1:0] openMeta_reg, openSync_reg;
	always_ff @(posedge clk_sys)
	begin
		busMeta_reg <= busCycPin;
		busSync_reg <= busMeta_reg;
		busPrev_reg <= busSync_reg;
		convMeta_reg <= convTrigPin;
		convSync_reg <= convMeta_reg;
		convPrev_reg <= convSync_reg;
		openMeta_reg <= openLinePin;
		openSync_reg <= openMeta_reg;
	end

	// state and data registers
	ai4_state_t state_reg;
	logic [1:0] ch_reg;
	logic [1:0] stg_reg;
	logic [23:0] cycTimer_reg;
	logic [15:0] sinceBus_reg;
	logic signed [15:0] raw_reg [NCH];
	logic signed [15:0] filtY_reg [NCH][MAXORD];
	logic signed [15:0] fx_reg;
	logic signed [31:0] scaled_reg;
	logic signed [15:0] minLat_reg [NCH];
	logic signed [15:0] maxLat_reg [NCH];
	logic [NCH-1:0] mmPrev_reg;
	logic sampViol_reg;
	logic trigPrev_reg;
	logic dumping_reg;
	logic [15:0] mem [FIFO_DEPTH];
	logic [AW-1:0] wrPtr_reg, rdPtr_reg;
	logic [AW:0] fill_reg;
	logic [31:0] tick_reg;
	logic [4:0] phase_reg;

	// decode of the current channel
	ai4_chcfg_t cc;
	logic busEdge, convEdge, lastCh, chEn;
	logic [2:0] ordEff;
	logic [15:0] aCoef;
	logic signed [47:0] fProd;
	logic signed [15:0] yNew;
	logic signed [63:0] kProd, sProd;
	logic signed [31:0] kGain, scaledMul;
	logic underNow, overNow, rangeNow;
	logic signed [31:0] clamped;
	logic [15:0] result;
	logic [NCH-1:0] mmEdge;
	logic [23:0] sampCyc;
	assign cc = chCfg[ch_reg];
	assign busEdge = busSync_reg & ~busPrev_reg;
	assign convEdge = convSync_reg & ~convPrev_reg;
	assign lastCh = (ch_reg == 2'(NCH - 1));
	assign chEn = cc.enable;
	assign ordEff = (cc.order > 3'(MAXORD)) ? 3'(MAXORD) : cc.order;
	assign sampCyc = 24'(sampleTimeUs) * 24'(CYC_PER_US);

	// first-order stage arithmetic
	assign aCoef = coefA(cc.cutoffHz, ordEff, sampleTimeUs);
	assign fProd = $signed({1'b0, aCoef}) * fx_reg
		+ $signed(A_ONE - {1'b0, aCoef}) * filtY_reg[ch_reg][stg_reg];
	assign yNew = fProd[30:15];

	// gain and offset, calibration combined with user values
	assign kProd = cc.calGain * cc.userGain;
	assign kGain = kProd[47:16];
	assign sProd = kGain * 32'(fx_reg);
	assign scaledMul = sProd[47:16] + cc.calOff + cc.userOff;

	// limit checks on 32-bit values and rail detection
	assign underNow = scaled_reg < cc.minLim;
	assign overNow = scaled_reg > cc.maxLim;
	assign clamped = underNow ? cc.minLim
		: (overNow ? cc.maxLim : scaled_reg);
	assign result = sat16(clamped);
	assign rangeNow = (raw_reg[ch_reg] == $signed(RAW_TOP))
		| (cc.isCurrent ? raw_reg[ch_reg] < 16'sd0
		: raw_reg[ch_reg] <= $signed(RAW_VBOT));

	// min/max period edges
	assign mmEdge = (trigRise & minMaxCtl & ~mmPrev_reg)
		| (trigFall & ~minMaxCtl & mmPrev_reg);

	// conversion and processing sequencer
	always_ff @(posedge clk_sys)
	begin
		adcReq <= 1'b0;
		if (rst)
		begin
			state_reg <= S_IDLE;
			ch_reg <= 2'd0;
			stg_reg <= 2'd0;
			adcChan <= 2'd0;
			cycleViol <= 1'b0;
			sampleCycleCnt <= CNT_ZERO;
		end
		else
		case (state_reg)
			S_IDLE:
				if (convEdge)
				begin
					ch_reg <= 2'd0;
					state_reg <= S_CREQ;
				end
			S_CREQ:
				if (chEn)
				begin
					adcReq <= 1'b1;
					adcChan <= ch_reg;
					state_reg <= S_CWAIT;
				end
				else if (lastCh)
				begin
					ch_reg <= 2'd0;
					state_reg <= S_PREP;
				end
				else
					ch_reg <= ch_reg + 2'd1;
			S_CWAIT:
				if (adcValid)
				begin
					ch_reg <= lastCh ? 2'd0 : ch_reg + 2'd1;
					state_reg <= lastCh ? S_PREP : S_CREQ;
				end
			S_PREP:
			begin
				stg_reg <= 2'd0;
				if (!chEn)
				begin
					ch_reg <= ch_reg + 2'd1;
					state_reg <= lastCh ? S_IDLE : S_PREP;
				end
				else if (cc.filtEn && ordEff != 3'd0)
					state_reg <= S_FILT;
				else
					state_reg <= S_SCALE;
			end
			S_FILT:
				if (3'(stg_reg) == ordEff - 3'd1)
					state_reg <= S_SCALE;
				else
					stg_reg <= stg_reg + 2'd1;
			S_SCALE:
				state_reg <= S_LIMIT;
			S_LIMIT:
			begin
				ch_reg <= ch_reg + 2'd1;
				state_reg <= lastCh ? S_IDLE : S_PREP;
			end
			default:
				state_reg <= S_IDLE;
		endcase
		if (!rst && state_reg != S_IDLE && state_reg != S_CREQ
			&& state_reg != S_CWAIT && lastCh
			&& (state_reg == S_LIMIT || (state_reg == S_PREP && !chEn)))
		begin
			cycleViol <= cycTimer_reg >= sampCyc;
			sampleCycleCnt <= CNT_W'(sampleCycleCnt + CNT_ONE);
		end
	end

	// sample data path per channel
	always_ff @(posedge clk_sys)
	begin
		if (state_reg == S_CWAIT && adcValid)
			raw_reg[ch_reg] <= adcData;
		if (state_reg == S_PREP)
			fx_reg <= raw_reg[ch_reg];
		if (state_reg == S_FILT)
			fx_reg <= yNew;
		// filter history starts from zero rather than unknown
		if (rst)
			filtY_reg <= '{default: 16'sh0000};
		else if (state_reg == S_FILT)
			filtY_reg[ch_reg][stg_reg] <= yNew;
		if (state_reg == S_SCALE)
			scaled_reg <= cc.scaleEn ? scaledMul : 32'(fx_reg);
	end

	// cycle timer and bus cycle distance
	always_ff @(posedge clk_sys)
	begin
		if (rst || state_reg == S_IDLE)
			cycTimer_reg <= 24'd0;
		else if (cycTimer_reg != 24'hFFFFFF)
			cycTimer_reg <= cycTimer_reg + 24'd1;
		if (rst || busEdge)
			sinceBus_reg <= 16'd0;
		else if (sinceBus_reg != 16'hFFFF)
			sinceBus_reg <= sinceBus_reg + 16'd1;
	end

	// sync and sampling cycle errors, judged at each trigger
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			syncErr <= 1'b0;
			sampViol_reg <= 1'b0;
			syncErrCnt <= CNT_ZERO;
			sampleViolCnt <= CNT_ZERO;
		end
		else if (convEdge)
		begin
			syncErr <= sinceBus_reg > 16'(SYNC_WIN_CYC);
			syncErrCnt <= evtCnt(syncErrCnt, syncErr,
				sinceBus_reg > 16'(SYNC_WIN_CYC));
			sampViol_reg <= state_reg != S_IDLE;
			sampleViolCnt <= evtCnt(sampleViolCnt, sampViol_reg,
				state_reg != S_IDLE);
		end
	end

	// per-channel results, flags, counters and min/max analysis
	always_ff @(posedge clk_sys)
	begin
		mmPrev_reg <= minMaxCtl;
		minMaxReadback <= minMaxCtl;
		if (rst)
		begin
			chValue <= '0;
			chUnder <= '0;
			chOver <= '0;
			chOutRange <= '0;
			chCnt <= '0;
			minValue <= '0;
			maxValue <= '0;
			mmPrev_reg <= '0;
			minMaxReadback <= '0;
			for (int i = 0; i < NCH; i++)
			begin
				minLat_reg[i] <= MIN_INIT;
				maxLat_reg[i] <= MAX_INIT;
			end
		end
		else
		begin
			for (int i = 0; i < NCH; i++)
				if (mmEdge[i])
				begin
					minValue[i] <= minLat_reg[i];
					maxValue[i] <= maxLat_reg[i];
					minLat_reg[i] <= MIN_INIT;
					maxLat_reg[i] <= MAX_INIT;
					chCnt[i].latch <= CNT_W'(chCnt[i].latch + CNT_ONE);
				end
			if (state_reg == S_LIMIT)
			begin
				chValue[ch_reg] <= result;
				chOutRange[ch_reg] <= rangeNow;
				chCnt[ch_reg].outRange <= evtCnt(chCnt[ch_reg].outRange,
					chOutRange[ch_reg], rangeNow);
				chUnder[ch_reg] <= underNow;
				chOver[ch_reg] <= overNow;
				if (cc.staticErr)
				begin
					chCnt[ch_reg].under <= evtCnt(chCnt[ch_reg].under,
						chUnder[ch_reg], underNow);
					chCnt[ch_reg].over <= evtCnt(chCnt[ch_reg].over,
						chOver[ch_reg], overNow);
				end
				if (cc.limitEn && mmEdge[ch_reg])
				begin
					minLat_reg[ch_reg] <= $signed(result);
					maxLat_reg[ch_reg] <= $signed(result);
				end
				else if (cc.limitEn)
				begin
					if ($signed(result) < minLat_reg[ch_reg])
						minLat_reg[ch_reg] <= $signed(result);
					if ($signed(result) > maxLat_reg[ch_reg])
						maxLat_reg[ch_reg] <= $signed(result);
				end
			end
		end
	end

	// recording FIFO with trigger-started readout
	logic fifoPush, fifoPop;
	assign fifoPush = state_reg == S_LIMIT && cc.recEn
		&& fill_reg != (AW + 1)'(FIFO_DEPTH);
	assign fifoPop = dumping_reg && fill_reg != '0
		&& (!traceValid || traceReady);
	always_ff @(posedge clk_sys)
	begin
		if (fifoPush)
			mem[wrPtr_reg] <= result;
		if (fifoPop)
			traceData <= mem[rdPtr_reg];
		trigPrev_reg <= traceTrig;
		if (rst)
		begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
			fill_reg <= '0;
			dumping_reg <= 1'b0;
			traceValid <= 1'b0;
			traceData <= 16'h0000;
			trigPrev_reg <= 1'b0;
		end
		else
		begin
			if (fifoPush)
				wrPtr_reg <= AW'(wrPtr_reg + 1'b1);
			if (fifoPop)
				rdPtr_reg <= AW'(rdPtr_reg + 1'b1);
			fill_reg <= (AW + 1)'(fill_reg + fifoPush - fifoPop);
			if (traceTrig && !trigPrev_reg)
				dumping_reg <= 1'b1;
			else if (fill_reg == '0)
				dumping_reg <= 1'b0;
			if (fifoPop)
				traceValid <= 1'b1;
			else if (traceReady)
				traceValid <= 1'b0;
		end
	end

	// lamp timebase and patterns
	logic fl1, fl2, blink, sysErr;
	assign fl1 = phase_reg < LED_FLASH1_END;
	assign fl2 = fl1 | (phase_reg >= LED_FLASH2_BEG
		&& phase_reg < LED_FLASH2_END);
	assign blink = ~phase_reg[2];
	assign sysErr = cycleViol | syncErr | sampViol_reg;
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			tick_reg <= 32'd0;
			phase_reg <= 5'd0;
			ledRun <= 1'b0;
			ledErr <= 1'b1;
			ledCh <= '0;
		end
		else
		begin
			tick_reg <= (tick_reg == 32'(TICK_CYC - 1)) ? 32'd0
				: tick_reg + 32'd1;
			if (tick_reg == 32'(TICK_CYC - 1))
				phase_reg <= (phase_reg == LED_FRAME_END) ? 5'd0
					: phase_reg + 5'd1;
			case (devState)
				DEV_RESET: ledRun <= fl1;
				DEV_BOOT: ledRun <= fl2;
				DEV_CONFIGURING_STATE: ledRun <= blink;
				default: ledRun <= 1'b1;
			endcase
			if (devState == DEV_RESET || modError)
				ledErr <= 1'b1;
			else
				ledErr <= sysErr & fl2;
			for (int i = 0; i < NCH; i++)
				ledCh[i] <= devState == DEV_RUN && chCfg[i].enable
					&& !(openSync_reg[i] && !chCfg[i].isCurrent);
		end
	end
endmodule

//--- ai4_proc_asserts.sv
// port-level concurrent checks for the analog input sequencer
module ai4_proc_asserts
	import ai4_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// watched inputs
	input ai4_dev_t devState,
	input wire logic modError,
	input ai4_chcfg_t [NCH-1:0] chCfg,
	input wire logic [NCH-1:0] minMaxCtl,
	input wire logic [NCH-1:0] trigRise,
	input wire logic [NCH-1:0] openLinePin,
	// watched outputs
	input wire logic adcReq,
	input wire logic [NCH-1:0][15:0] chValue,
	input wire logic [NCH-1:0] minMaxReadback,
	input wire logic [NCH-1:0] chUnder,
	input wire logic [NCH-1:0] chOver,
	input wire logic syncErr,
	input wire logic [CNT_W-1:0] syncErrCnt,
	input ai4_chcnt_t [NCH-1:0] chCnt,
	input wire logic ledRun,
	input wire logic ledErr,
	input wire logic [NCH-1:0] ledCh
);
	default clocking dc @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	// converter handshake, counters and limits
	adc_req_pulse_a: assert property (adcReq |=> !adcReq)
		else $error("converter request longer than one cycle");
	sync_cnt_lsb_a: assert property (syncErrCnt[0] == syncErr)
		else $error("sync counter lsb differs from sync flag");
	sync_cnt_step_a: assert property ($changed(syncErrCnt) |->
		syncErrCnt == $past(syncErrCnt) + CNT_ONE)
		else $error("sync counter stepped by other than one");
	under_holds_min_a: assert property (chUnder[0] &&
		chCfg[0].minLim >= -32768 |-> chValue[0] == chCfg[0].minLim[15:0])
		else $error("undershoot result not at minimum limit");
	over_holds_max_a: assert property (chOver[0] &&
		chCfg[0].maxLim <= 32767 |-> chValue[0] == chCfg[0].maxLim[15:0])
		else $error("overshoot result not at maximum limit");
	latch_count_a: assert property (trigRise[0] && minMaxCtl[0] &&
		!minMaxReadback[0] && chCfg[0].limitEn |=>
		chCnt[0].latch == $past(chCnt[0].latch) + CNT_ONE)
		else $error("period start did not bump latch counter");

	// lamps
	err_lamp_reset_a: assert property ($fell(rst) |-> ledErr)
		else $error("error lamp dark on leaving reset");
	err_lamp_fault_a: assert property (modError [*3] |-> ledErr)
		else $error("error lamp dark during module error");
	run_lamp_on_a: assert property ((devState == DEV_RUN) [*3] |-> ledRun)
		else $error("run lamp dark in run state");
	open_line_dark_a: assert property ((openLinePin[0] &&
		!chCfg[0].isCurrent) [*6] |-> !ledCh[0])
		else $error("channel lamp lit on open voltage line");

	// main scenarios reached
	req_c: cover property (adcReq);
	under_c: cover property (chUnder[0]);
	sync_c: cover property (syncErr);
	latch_c: cover property ($changed(chCnt[0].latch));
endmodule

bind ai4_proc ai4_proc_asserts chk_u (.clk_sys, .rst, .devState, .modError,
	.chCfg, .minMaxCtl, .trigRise, .openLinePin, .adcReq, .chValue,
	.minMaxReadback, .chUnder, .chOver, .syncErr, .syncErrCnt, .chCnt,
	.ledRun, .ledErr, .ledCh);

//--- tb.sv
// self-checking bench for the analog input sequencer
module tb
	import ai4_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	ai4_dev_t devState = DEV_RUN;
	logic modError = 1'b0;
	logic traceTrig = 1'b0;
	logic traceReady = 1'b0;
	logic busCycPin = 1'b0;
	logic convTrigPin = 1'b0;
	ai4_chcfg_t [NCH-1:0] chCfg;
	logic [15:0] sampleTimeUs = 16'h0064;
	logic [NCH-1:0] minMaxCtl = 4'h0;
	logic [NCH-1:0] trigRise = 4'hF;
	logic [NCH-1:0] trigFall = 4'h0;
	logic [NCH-1:0] openLinePin = 4'h0;
	logic traceValid, adcReq, adcValid, syncErr, cycleViol, ledRun, ledErr;
	logic [15:0] traceData, adcData;
	logic [1:0] adcChan;
	logic [NCH-1:0][15:0] chValue, minValue, maxValue;
	logic [NCH-1:0][15:0] rawIn = '0;
	logic [NCH-1:0] minMaxReadback, chUnder, chOver, chOutRange, ledCh;
	logic [CNT_W-1:0] sampleCycleCnt, syncErrCnt, sampleViolCnt;
	ai4_chcnt_t [NCH-1:0] chCnt;
	logic [7:0] delay = 8'h03;
	logic [31:0] seed = 32'h0000_0BDF;
	logic [15:0] edgeVal[4] = '{16'h7FFF, 16'h8000, 16'h8001, 16'h0000};
	int litExp[4] = '{16, 32, 48, 96};
	int fails = 0;
	int tests_run = 0;
	int mdCnt[NCH][3];
	bit mdFlag[NCH][3];
	real fy[NCH][MAXORD];
	int mdMin[NCH], mdMax[NCH], mdLatch[NCH];
	int mdSyncCnt = 0;
	bit mdSync = 1'b0;
	bit recOn = 1'b0;
	int trq[$];
	int lit, n;

	ai4_proc #(.TICK_CYC(4), .FIFO_DEPTH(16)) dut_u (.clk_sys, .rst,
		.devState, .modError, .chCfg, .sampleTimeUs, .minMaxCtl, .trigRise,
		.trigFall, .traceTrig, .traceReady, .traceValid, .traceData,
		.busCycPin, .convTrigPin, .openLinePin, .adcReq, .adcChan, .adcValid,
		.adcData, .chValue, .minValue, .maxValue, .minMaxReadback, .chUnder,
		.chOver, .chOutRange, .syncErr, .cycleViol, .sampleCycleCnt,
		.syncErrCnt, .sampleViolCnt, .chCnt, .ledRun, .ledErr, .ledCh);
	ai4_adc_model adc_u (.clk_sys, .adcReq, .adcChan, .adcValid, .adcData,
		.rawIn, .delay);

	// 250 MHz clock
	always #2 clk_sys = ~clk_sys;

	// helpers: random source, compare, verdict
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic chk(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			fails++;
			$display("unexpected %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask

	task automatic close_out();
		if (fails == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// reference model of one finished cycle, compared channel by channel
	task automatic expect_cycle(input int gap);
		longint v, k;
		logic [15:0] r;
		bit f[3];
		real fa, fx, ts;
		if ((gap + 2 > SYNC_WIN_CYC) != mdSync)
			mdSyncCnt++;
		mdSync = gap + 2 > SYNC_WIN_CYC;
		chk("syncErr", syncErr, mdSync);
		chk("syncErrCnt", syncErrCnt, mdSyncCnt);
		for (int i = 0; i < NCH; i++)
		begin
			if (!chCfg[i].enable)
				continue;
			r = rawIn[i];
			v = $signed(r);
			if (chCfg[i].scaleEn)
			begin
				k = (longint'(chCfg[i].calGain) * chCfg[i].userGain) >>> 16;
				v = ((k * v) >>> 16) + chCfg[i].calOff + chCfg[i].userOff;
			end
			f[1] = v < chCfg[i].minLim;
			f[2] = v > chCfg[i].maxLim;
			v = f[1] ? chCfg[i].minLim : f[2] ? chCfg[i].maxLim : v;
			v = v > 32767 ? 32767 : v < -32768 ? -32768 : v;
			f[0] = r == RAW_TOP || (chCfg[i].isCurrent ? r[15] :
				$signed(r) <= $signed(RAW_VBOT));
			for (int j = 0; j < 3; j++)
				if (j == 0 || chCfg[i].staticErr)
				begin
					mdCnt[i][j] += f[j] != mdFlag[i][j];
					mdFlag[i][j] = f[j];
				end
			if (chCfg[i].filtEn)
			begin
				fx = $signed(r);
				ts = 1.0e-6 * sampleTimeUs;
				fa = $sqrt(2.0 ** (1.0 / chCfg[i].order) - 1.0);
				fa = ts / (ts + fa / (6.2831853 * chCfg[i].cutoffHz));
				for (int s = 0; s < chCfg[i].order; s++)
				begin
					fy[i][s] = fa * fx + (1.0 - fa) * fy[i][s];
					fx = fy[i][s];
				end
				fx = fx - $signed(chValue[i]);
				chk("filtValue", fx * fx < 64.0, 1);
			end
			else
				chk("chValue", chValue[i], v[15:0]);
			chk("chOutRange", chOutRange[i], f[0]);
			chk("chUnder", chUnder[i], f[1]);
			chk("chOver", chOver[i], f[2]);
			chk("outRangeCnt", chCnt[i].outRange, mdCnt[i][0]);
			chk("underCnt", chCnt[i].under, mdCnt[i][1]);
			chk("overCnt", chCnt[i].over, mdCnt[i][2]);
			if (chCfg[i].limitEn)
			begin
				mdMin[i] = v < mdMin[i] ? int'(v) : mdMin[i];
				mdMax[i] = v > mdMax[i] ? int'(v) : mdMax[i];
			end
			if (recOn && chCfg[i].recEn && trq.size() < 16)
				trq.push_back(v[15:0]);
		end
	endtask

	// bus cycle edge, trigger after a gap, wait for the cycle to finish
	task automatic conv(input int gap);
		logic [CNT_W-1:0] c0;
		int w;
		c0 = sampleCycleCnt;
		busCycPin = 1'b1;
		repeat (2) @(negedge clk_sys);
		busCycPin = 1'b0;
		repeat (gap) @(negedge clk_sys);
		convTrigPin = 1'b1;
		repeat (2) @(negedge clk_sys);
		convTrigPin = 1'b0;
		w = 0;
		while (sampleCycleCnt === c0 && w < 3000)
		begin
			@(negedge clk_sys);
			w++;
		end
		@(negedge clk_sys);
		chk("cycleCnt", sampleCycleCnt, c0 + 16'h0001);
		expect_cycle(gap);
	endtask

	// rising control edge publishes, falling edge is ignored
	task automatic period();
		minMaxCtl[0] = 1'b1;
		repeat (2) @(negedge clk_sys);
		mdLatch[0]++;
		chk("readback", minMaxReadback[0], 1);
		chk("minValue", minValue[0], mdMin[0][15:0]);
		chk("maxValue", maxValue[0], mdMax[0][15:0]);
		minMaxCtl[0] = 1'b0;
		repeat (2) @(negedge clk_sys);
		chk("latchCnt", chCnt[0].latch, mdLatch[0]);
		mdMin[0] = 32767;
		mdMax[0] = -32768;
	endtask

	// watchdog
	initial
	begin
		#400000;
		fails++;
		close_out();
	end

	// main sequence
	initial
	begin
		chCfg = '0;
		for (int i = 0; i < NCH; i++)
		begin
			chCfg[i].enable = 1'b1;
			chCfg[i].isCurrent = i == 3;
			chCfg[i].scaleEn = i == 1;
			chCfg[i].staticErr = i != 2;
			chCfg[i].limitEn = 1'b1;
			chCfg[i].calGain = 32'h0001_0000;
			chCfg[i].userGain = 32'h0001_8000;
			chCfg[i].calOff = 32'h0000_0010;
			chCfg[i].userOff = 32'hFFFF_FF9C;
			chCfg[i].minLim = i == 2 ? 32'hFFFF_8000 : 32'hFFFF_B1E0;
			chCfg[i].maxLim = i == 2 ? 32'h0000_7FFF : 32'h0000_4E20;
			mdMin[i] = 32767;
			mdMax[i] = -32768;
		end
		repeat (12) @(negedge clk_sys);
		chk("ledErr", ledErr, 1);
		chk("syncErrCnt", syncErrCnt, 0);
		rst = 1'b0;
		for (int c = 0; c < 16; c++)
		begin
			for (int i = 0; i < NCH; i++)
				rawIn[i] = c < 4 ? edgeVal[(c + i) % 4] : 16'(rnd());
			chCfg[2].enable = c != 9;
			conv(5);
			if (c % 6 == 5)
				period();
		end
		conv(1300);
		lit = 0;
		repeat (96)
		begin
			@(negedge clk_sys);
			lit += ledErr;
		end
		chk("ledErrFlash", lit, 32);
		conv(5);
		sampleTimeUs = 16'h0001;
		delay = 8'h50;
		fork
			conv(5);
			begin
				repeat (60) @(negedge clk_sys);
				convTrigPin = 1'b1;
				repeat (2) @(negedge clk_sys);
				convTrigPin = 1'b0;
			end
		join
		chk("sampleViol", sampleViolCnt[0], 1);
		chk("cycleViol", cycleViol, 1);
		sampleTimeUs = 16'h0064;
		delay = 8'h03;
		conv(5);
		chk("cycleViol", cycleViol, 0);
		recOn = 1'b1;
		chCfg[0].recEn = 1'b1;
		repeat (20)
		begin
			for (int i = 0; i < NCH; i++)
				rawIn[i] = 16'(rnd());
			conv(5);
		end
		traceTrig = 1'b1;
		repeat (2) @(negedge clk_sys);
		traceTrig = 1'b0;
		n = 0;
		while (trq.size() > 0 && n < 500)
		begin
			@(negedge clk_sys);
			traceReady = 1'(rnd());
			if (traceReady && traceValid === 1'b1)
				chk("traceData", traceData, trq.pop_front());
			n++;
		end
		repeat (3) @(negedge clk_sys);
		traceReady = 1'b0;
		chk("traceValid", traceValid, 0);
		chCfg[2].filtEn = 1'b1;
		chCfg[2].order = 3'd2;
		chCfg[2].cutoffHz = 16'h0400;
		repeat (4)
		begin
			rawIn = {16'(rnd()), 16'h3E80, 16'(rnd()), 16'(rnd())};
			conv(5);
		end
		openLinePin = 4'h9;
		modError = 1'b1;
		repeat (10) @(negedge clk_sys);
		chk("ledCh", ledCh, 4'hE);
		chk("ledErr", ledErr, 1);
		modError = 1'b0;
		for (int s = 0; s < 4; s++)
		begin
			devState = ai4_dev_t'(s);
			repeat (2) @(negedge clk_sys);
			lit = 0;
			repeat (96)
			begin
				@(negedge clk_sys);
				lit += ledRun;
			end
			chk("ledRun", lit, litExp[s]);
		end
		close_out();
	end
endmodule
